/* File: hw/sctr_cfg.svh */
`ifndef SCTR_CFG_SVH
`define SCTR_CFG_SVH

// default 7-bit bus address of this part
`define SCTR_SLAVE_ADDR 7'h60
// only register, always pointed at
`define SCTR_REG_ADDR 8'h00
// value of the configuration register after reset
`define SCTR_CFG_RESET 8'h00
// writable bits of the register; bit 2 is reserved
`define SCTR_CFG_WMASK 8'hfb
// bits in one byte on the bus
`define SCTR_BYTE_BITS 4'h8
// first value of the bit counter
`define SCTR_BIT_ZERO 4'h0
// bit counter step
`define SCTR_BIT_STEP 4'h1
// busy counter load at stop; the busy window after stop lasts one clock longer than this
`define SCTR_WR_CYC 2'h2
// busy counter step
`define SCTR_BUSY_STEP 2'h1
// busy counter end value
`define SCTR_BUSY_ZERO 2'h0

`endif

/* File: hw/sctr_pkg.sv */
package sctr_pkg;

    // layout of the configuration register, msb first
    typedef struct packed {
        logic regDisable;    // 1 turns the regulator off
        logic pinModeSel;    // 0 reset pass-through, 1 enable pin
        logic cardRstLevel;  // software card reset level
        logic outLatch;      // freeze card clock, data and pass-through reset
        logic enPolarity;    // 0 high enables, 1 low enables
        logic reserved2;     // reads zero
        logic voltSel;       // 0 1.8 V, 1 3 V
        logic devEnable;     // device enable / pin status
    } sctr_cfg_t;

    // serial slave sequencer
    typedef enum logic [3:0] {
        SER_IDLE,
        SER_ADDR,
        SER_ACK_ADDR,
        SER_WRITE,
        SER_ACK_WRITE,
        SER_READ,
        SER_ACK_READ,
        SER_IGNORE,
        SER_BUSY
    } sctr_ser_t;

    // who pulls the data line low first
    typedef enum logic [1:0] {
        OWN_NONE,
        OWN_HOST,
        OWN_CARD
    } sctr_own_t;

    // card side outputs carried together
    typedef struct packed {
        logic clock;
        logic reset;
        logic dataLow;
    } sctr_card_t;

endpackage : sctr_pkg

/* File: hw/sctr_config_reg.sv */
// Behaviour
// - one 8-bit register at address 00h
// - bit 7 disables regulator, paths stay alive
// - bit 6 clear: host pin drives card reset
// - bit 6 set: host pin enables device
// - bit 6 set: bit 5 sets card reset
// - bit 4 freezes card clock, data and pass-through reset at host states
// - latch lets two devices stop clock
// - bit 3 picks enable pin polarity
// - bit 1 picks 1.8 V or 3 V
// - bit 0 enable, or pin status when bit 6
// - defined bits reset to zero
// - no subaddress; a write applies only its last data byte, a read repeats the byte on ack
// - apply write at stop, ignore while busy
// - reset clears register and serial sequencer
`include "sctr_cfg.svh"

module sctr_config_reg #(
    parameter logic [6:0] SLAVE_ADDR = `SCTR_SLAVE_ADDR
) (
    input  wire logic              clk_sys,         // 50 MHz system clock
    input  wire logic              rst,             // synchronous reset, high
    input  wire logic              sclIn,           // bus clock level
    input  wire logic              sdaIn,           // bus data level
    output logic                   sdaOut,          // bus data drive value, always 0
    output logic                   sdaOeN,          // low while pulling data low
    input  wire logic              hostDataIn,      // host data pin level
    output logic                   hostDataOut,     // host data drive value
    output logic                   hostDataOeN,     // low while driving host data
    input  wire logic              hostClkIn,       // host clock pin
    input  wire logic              hostRstEnIn,     // host reset / enable pin
    input  wire logic              cardDataIn,      // card data pin level
    output logic                   cardDataOut,     // card data drive value
    output logic                   cardDataOeN,     // low while driving card data
    output logic                   cardClockOut,    // card clock
    output logic                   cardResetOut,    // card reset
    output logic                   regulatorEnable, // regulator on
    output logic                   voltageSelect,   // 0 1.8 V, 1 3 V
    output logic                   deviceActive,    // device enabled
    output sctr_pkg::sctr_cfg_t    cfgOut           // current register contents
);
    import sctr_pkg::*;

    // register contents as read back, bit 0 swapped for pin state in enable mode
    function automatic logic [7:0] readView(input sctr_cfg_t c, input logic pin);
        sctr_cfg_t v;
        v = c;
        v.reserved2 = 1'b0;
        if (c.pinModeSel)
        begin
            v.devEnable = pin;
        end
        return v;
    endfunction : readView

    sctr_cfg_t      cfg_q, cfg_d;
    sctr_ser_t      ser_q, ser_d;
    logic [3:0]     bitCnt_q, bitCnt_d;
    logic [7:0]     rxSh_q, rxSh_d;
    logic [7:0]     txSh_q, txSh_d;
    logic [7:0]     pend_q, pend_d;
    logic           pendOk_q, pendOk_d;
    logic           rdDir_q, rdDir_d;
    logic           mAck_q, mAck_d;
    logic           sdaDrv_q, sdaDrv_d;
    logic [1:0]     busy_q, busy_d;
    logic           sclPrev_q, sdaPrev_q;
    logic           sclRise, sclFall, startSeen, stopSeen;
    logic [7:0]     rdVal;
    logic [7:0]     wrVal;

    // bus edges and framing conditions, inputs already in this clock domain
    assign sclRise   = sclIn & ~sclPrev_q;
    assign sclFall   = ~sclIn & sclPrev_q;
    assign startSeen = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
    assign stopSeen  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
    assign rdVal     = readView(cfg_q, hostRstEnIn);
    assign wrVal     = pend_q & `SCTR_CFG_WMASK;

    // serial sequencer and register update
    always_comb
    begin
        cfg_d    = cfg_q;
        ser_d    = ser_q;
        bitCnt_d = bitCnt_q;
        rxSh_d   = rxSh_q;
        txSh_d   = txSh_q;
        pend_d   = pend_q;
        pendOk_d = pendOk_q;
        rdDir_d  = rdDir_q;
        mAck_d   = mAck_q;
        sdaDrv_d = sdaDrv_q;
        busy_d   = busy_q;
        if (ser_q == SER_BUSY)
        begin
            // internal write: the bus is not watched, even a start is lost
            sdaDrv_d = 1'b0;
            if (busy_q == `SCTR_BUSY_ZERO)
            begin
                ser_d = SER_IDLE;
            end
            else
            begin
                busy_d = busy_q - `SCTR_BUSY_STEP;
            end
        end
        else if (stopSeen)
        begin
            sdaDrv_d = 1'b0;
            pendOk_d = 1'b0;
            if (pendOk_q)
            begin
                // the register at 00h takes the byte only now
                cfg_d = sctr_cfg_t'(wrVal);
                if (cfg_d.pinModeSel)
                begin
                    cfg_d.devEnable = cfg_q.devEnable;
                end
                busy_d = `SCTR_WR_CYC;
                ser_d  = SER_BUSY;
            end
            else
            begin
                ser_d = SER_IDLE;
            end
        end
        else if (startSeen)
        begin
            // repeated start drops any byte not yet closed by a stop
            ser_d    = SER_ADDR;
            bitCnt_d = `SCTR_BIT_ZERO;
            sdaDrv_d = 1'b0;
            pendOk_d = 1'b0;
        end
        else
        begin
            case (ser_q)
                SER_ADDR:
                begin
                    if (sclRise)
                    begin
                        rxSh_d   = {rxSh_q[6:0], sdaIn};
                        bitCnt_d = bitCnt_q + `SCTR_BIT_STEP;
                    end
                    else if (sclFall && bitCnt_q == `SCTR_BYTE_BITS)
                    begin
                        if (rxSh_q[7:1] == SLAVE_ADDR)
                        begin
                            rdDir_d  = rxSh_q[0];
                            sdaDrv_d = 1'b1;
                            ser_d    = SER_ACK_ADDR;
                        end
                        else
                        begin
                            ser_d = SER_IGNORE;
                        end
                    end
                end
                SER_ACK_ADDR:
                begin
                    // no subaddress: data follows the address at once
                    if (sclFall)
                    begin
                        bitCnt_d = `SCTR_BIT_ZERO;
                        if (rdDir_q)
                        begin
                            txSh_d   = rdVal;
                            sdaDrv_d = ~rdVal[7];
                            ser_d    = SER_READ;
                        end
                        else
                        begin
                            sdaDrv_d = 1'b0;
                            ser_d    = SER_WRITE;
                        end
                    end
                end
                SER_WRITE:
                begin
                    if (sclRise)
                    begin
                        rxSh_d   = {rxSh_q[6:0], sdaIn};
                        bitCnt_d = bitCnt_q + `SCTR_BIT_STEP;
                    end
                    else if (sclFall && bitCnt_q == `SCTR_BYTE_BITS)
                    begin
                        pend_d   = rxSh_q;
                        pendOk_d = 1'b1;
                        sdaDrv_d = 1'b1;
                        ser_d    = SER_ACK_WRITE;
                    end
                end
                SER_ACK_WRITE:
                begin
                    // further bytes overwrite the pending one; last one wins
                    if (sclFall)
                    begin
                        sdaDrv_d = 1'b0;
                        bitCnt_d = `SCTR_BIT_ZERO;
                        ser_d    = SER_WRITE;
                    end
                end
                SER_READ:
                begin
                    if (sclRise)
                    begin
                        bitCnt_d = bitCnt_q + `SCTR_BIT_STEP;
                    end
                    else if (sclFall)
                    begin
                        if (bitCnt_q == `SCTR_BYTE_BITS)
                        begin
                            sdaDrv_d = 1'b0;
                            ser_d    = SER_ACK_READ;
                        end
                        else
                        begin
                            txSh_d   = {txSh_q[6:0], 1'b0};
                            sdaDrv_d = ~txSh_q[6];
                        end
                    end
                end
                SER_ACK_READ:
                begin
                    // ack repeats the same byte, nack ends the transfer
                    if (sclRise)
                    begin
                        mAck_d = ~sdaIn;
                    end
                    else if (sclFall)
                    begin
                        if (mAck_q)
                        begin
                            bitCnt_d = `SCTR_BIT_ZERO;
                            txSh_d   = rdVal;
                            sdaDrv_d = ~rdVal[7];
                            ser_d    = SER_READ;
                        end
                        else
                        begin
                            ser_d = SER_IGNORE;
                        end
                    end
                end
                default:
                begin
                    sdaDrv_d = 1'b0;
                end
            endcase
        end
    end

    // register and sequencer state; reset restores defaults
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cfg_q     <= sctr_cfg_t'(`SCTR_CFG_RESET);
            ser_q     <= SER_IDLE;
            bitCnt_q  <= `SCTR_BIT_ZERO;
            rxSh_q    <= `SCTR_CFG_RESET;
            txSh_q    <= `SCTR_CFG_RESET;
            pend_q    <= `SCTR_CFG_RESET;
            pendOk_q  <= 1'b0;
            rdDir_q   <= 1'b0;
            mAck_q    <= 1'b0;
            sdaDrv_q  <= 1'b0;
            busy_q    <= `SCTR_BUSY_ZERO;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            cfg_q     <= cfg_d;
            ser_q     <= ser_d;
            bitCnt_q  <= bitCnt_d;
            rxSh_q    <= rxSh_d;
            txSh_q    <= txSh_d;
            pend_q    <= pend_d;
            pendOk_q  <= pendOk_d;
            rdDir_q   <= rdDir_d;
            mAck_q    <= mAck_d;
            sdaDrv_q  <= sdaDrv_d;
            busy_q    <= busy_d;
            sclPrev_q <= sclIn;
            sdaPrev_q <= sdaIn;
        end
    end

    sctr_own_t  own_q, own_d;
    sctr_card_t hold_q, hold_d;
    sctr_card_t card_q, card_d;
    logic       hostLow_q, hostLow_d;
    logic       active_q, active_d;
    logic       regOn_q, regOn_d;
    logic       volt_q, volt_d;

    // enable, data direction, latch and card side outputs
    always_comb
    begin
        own_d = own_q;
        if (cfg_q.pinModeSel)
        begin
            active_d = hostRstEnIn ^ cfg_q.enPolarity;
        end
        else
        begin
            active_d = cfg_q.devEnable;
        end
        // direction goes to the side that falls first from both high;
        // a low we drive ourselves is our own echo, else the lines ping-pong
        case (own_q)
            OWN_NONE:
            begin
                if (!hostDataIn && !hostLow_q)
                begin
                    own_d = OWN_HOST;
                end
                else if (!cardDataIn && !card_q.dataLow)
                begin
                    own_d = OWN_CARD;
                end
            end
            OWN_HOST:
            begin
                if (hostDataIn)
                begin
                    own_d = OWN_NONE;
                end
            end
            OWN_CARD:
            begin
                if (cardDataIn)
                begin
                    own_d = OWN_NONE;
                end
            end
            default:
            begin
                own_d = OWN_NONE;
            end
        endcase
        hostLow_d    = active_q && (own_q == OWN_CARD);
        hold_d       = hold_q;
        hold_d.clock = hostClkIn;
        hold_d.reset = cfg_q.pinModeSel ? cfg_q.cardRstLevel : hostRstEnIn;
        hold_d.dataLow = (own_q == OWN_HOST);
        if (cfg_q.outLatch)
        begin
            // frozen outputs let a second device share the host clock
            hold_d.clock   = hold_q.clock;
            hold_d.dataLow = hold_q.dataLow;
            if (!cfg_q.pinModeSel)
            begin
                hold_d.reset = hold_q.reset;
            end
        end
        // a disabled device parks the card lines low
        if (active_q)
        begin
            card_d = hold_q;
        end
        else
        begin
            card_d = '{clock: 1'b0, reset: 1'b0, dataLow: 1'b1};
        end
        regOn_d = ~cfg_q.regDisable;
        volt_d  = cfg_q.voltSel;
    end

    // card path registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            own_q     <= OWN_NONE;
            hold_q    <= '0;
            card_q    <= '{clock: 1'b0, reset: 1'b0, dataLow: 1'b1};
            hostLow_q <= 1'b0;
            active_q  <= 1'b0;
            regOn_q   <= 1'b0;
            volt_q    <= 1'b0;
        end
        else
        begin
            own_q     <= own_d;
            hold_q    <= hold_d;
            card_q    <= card_d;
            hostLow_q <= hostLow_d;
            active_q  <= active_d;
            regOn_q   <= regOn_d;
            volt_q    <= volt_d;
        end
    end

    // pins; regulator state does not gate the signal paths
    assign sdaOut          = 1'b0;
    assign sdaOeN          = ~sdaDrv_q;
    assign hostDataOut     = 1'b0;
    assign hostDataOeN     = ~hostLow_q;
    assign cardDataOut     = 1'b0;
    assign cardDataOeN     = ~card_q.dataLow;
    assign cardClockOut    = card_q.clock;
    assign cardResetOut    = card_q.reset;
    assign regulatorEnable = regOn_q;
    assign voltageSelect   = volt_q;
    assign deviceActive    = active_q;
    assign cfgOut          = cfg_q;

endmodule : sctr_config_reg

/* File: verif/sctr_sva.sv */
module sctr_sva (
    input wire logic           clk_sys,         // system clock
    input wire logic           rst,             // sync reset, high
    input wire logic           sclIn,           // bus clock level
    input wire logic           sdaOeN,          // low while device pulls data
    input wire logic           hostRstEnIn,     // host reset / enable pin
    input wire logic           cardClockOut,    // card clock
    input wire logic           cardResetOut,    // card reset
    input wire logic           regulatorEnable, // regulator on
    input wire logic           voltageSelect,   // supply level pick
    input wire logic           deviceActive,    // device enabled
    input sctr_pkg::sctr_cfg_t cfgOut           // stored register
);
    timeunit 1ns;
    timeprecision 1ps;
    import sctr_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // outputs are judged only once the register has sat still past their latency
    sequence s_cfgSteady;
        ($stable(cfgOut))[*3];
    endsequence
    sequence s_pinMode;
        ($stable(cfgOut) && $stable(hostRstEnIn) && cfgOut.pinModeSel)[*3];
    endsequence
    sequence s_passMode;
        ($stable(cfgOut) && $stable(hostRstEnIn) && !cfgOut.pinModeSel
            && !cfgOut.outLatch && cfgOut.devEnable)[*5];
    endsequence
    sequence s_latched;
        ($stable(cfgOut) && cfgOut.outLatch && cfgOut.devEnable && !cfgOut.pinModeSel)[*4];
    endsequence

    // reset must win even mid-transfer, so this one is never disabled
    property p_reset;
        disable iff (1'b0) rst |=> cfgOut == 8'h00 && sdaOeN;
    endproperty
    property p_rsvd;
        cfgOut.reserved2 == 1'b0;
    endproperty
    property p_reg;
        s_cfgSteady |-> regulatorEnable == !cfgOut.regDisable;
    endproperty
    property p_volt;
        s_cfgSteady |-> voltageSelect == cfgOut.voltSel;
    endproperty
    property p_enPin;
        s_pinMode |-> deviceActive == (hostRstEnIn ^ cfgOut.enPolarity);
    endproperty
    property p_enBit;
        ($stable(cfgOut) && !cfgOut.pinModeSel)[*3] |-> deviceActive == cfgOut.devEnable;
    endproperty
    property p_rstLevel;
        s_pinMode ##1 s_pinMode ##0 deviceActive |-> cardResetOut == cfgOut.cardRstLevel;
    endproperty
    property p_rstPass;
        s_passMode |-> cardResetOut == hostRstEnIn;
    endproperty
    property p_latch;
        s_latched |-> $stable(cardClockOut) && $stable(cardResetOut);
    endproperty
    // data may only move while the bus clock is low, else it reads as start or stop
    property p_sdaPhase;
        $changed(sdaOeN) |-> !sclIn;
    endproperty

    a_reset: assert property (p_reset) else $error("register not cleared by reset");
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    a_reg: assert property (p_reg) else $error("regulator enable mismatch");
    a_volt: assert property (p_volt) else $error("voltage select mismatch");
    a_enPin: assert property (p_enPin) else $error("enable pin polarity wrong");
    a_enBit: assert property (p_enBit) else $error("enable bit not obeyed");
    a_rstLevel: assert property (p_rstLevel) else $error("card reset level wrong");
    a_rstPass: assert property (p_rstPass) else $error("card reset not passed");
    a_latch: assert property (p_latch) else $error("latched outputs moved");
    a_sdaPhase: assert property (p_sdaPhase) else $error("data moved with clock high");
endmodule : sctr_sva

bind sctr_config_reg sctr_sva chk_u (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .sclIn          (sclIn),
    .sdaOeN         (sdaOeN),
    .hostRstEnIn    (hostRstEnIn),
    .cardClockOut   (cardClockOut),
    .cardResetOut   (cardResetOut),
    .regulatorEnable(regulatorEnable),
    .voltageSelect  (voltageSelect),
    .deviceActive   (deviceActive),
    .cfgOut         (cfgOut)
);

/* File: verif/sctr_host_model.sv */
module sctr_host_model (
    input wire logic clk_sys, // system clock
    input wire logic sda,     // resolved data line
    output logic     scl,     // bus clock, idles high
    output logic     sdaDrv   // 0 pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idles released
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    // one bit: twelve clocks, data set mid-low, sampled mid-high
    task automatic xbit(input logic b, output logic r);
        tick(3);
        sdaDrv = b;
        tick(3);
        scl = 1'b1;
        tick(3);
        r = sda;
        tick(3);
        scl = 1'b0;
    endtask : xbit

    task automatic start;
        sdaDrv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b0;
    endtask : start

    // n is the idle time left after the stop
    task automatic stop(input int n);
        tick(3);
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b1;
        tick(n);
    endtask : stop

    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask : wrByte

    task automatic rdByte(output logic [7:0] d, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(nack, r);
    endtask : rdByte

    // no subaddress: address byte then one data byte
    task automatic wrReg(input logic [6:0] a, input logic [7:0] d, output logic ack);
        logic a1;
        logic a2;
        start();
        wrByte({a, 1'b0}, a1);
        wrByte(d, a2);
        stop(3);
        ack = a1 && a2;
    endtask : wrReg

    task automatic rdReg(input logic [6:0] a, output logic [7:0] d, output logic ack);
        start();
        wrByte({a, 1'b1}, ack);
        rdByte(d, 1'b1);
        stop(3);
    endtask : rdReg

    // write, then a new start one clock after stop, inside the apply window
    task automatic busyProbe(input logic [6:0] a, input logic [7:0] d, output logic ack);
        logic x;
        start();
        wrByte({a, 1'b0}, x);
        wrByte(d, x);
        stop(1);
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b0;
        wrByte({a, 1'b1}, ack);
        stop(3);
    endtask : busyProbe
endmodule : sctr_host_model

/* File: verif/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sctr_pkg::*;

    localparam logic [6:0] DEV_ADDR = 7'h61;
    localparam int         LIMIT    = 20000;

    logic       clk_sys     = 1'b0;
    logic       rst         = 1'b1;
    logic       hostClkIn   = 1'b0;
    logic       hostRstEnIn = 1'b0;
    logic       hostDrv     = 1'b1;
    logic       cardDrv     = 1'b1;
    int         miscompares = 0;
    int         checked     = 0;
    int         cycles      = 0;
    logic       scl, sdaDrv, sda, sdaOut, sdaOeN;
    logic       hostDataIn, hostDataOut, hostDataOeN;
    logic       cardDataIn, cardDataOut, cardDataOeN;
    logic       cardClockOut, cardResetOut, regulatorEnable, voltageSelect, deviceActive;
    sctr_cfg_t  cfgOut;

    always #10 clk_sys = ~clk_sys;

    // open-drain wires: low if any party drives low
    assign sda = sdaDrv & (sdaOeN ? 1'b1 : sdaOut);
    assign hostDataIn = hostDrv & (hostDataOeN ? 1'b1 : hostDataOut);
    assign cardDataIn = cardDrv & (cardDataOeN ? 1'b1 : cardDataOut);

    sctr_host_model host_u (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sdaDrv(sdaDrv));

    sctr_config_reg #(.SLAVE_ADDR(DEV_ADDR)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOeN(hostDataOeN), .hostClkIn(hostClkIn), .hostRstEnIn(hostRstEnIn),
        .cardDataIn(cardDataIn), .cardDataOut(cardDataOut), .cardDataOeN(cardDataOeN),
        .cardClockOut(cardClockOut), .cardResetOut(cardResetOut),
        .regulatorEnable(regulatorEnable), .voltageSelect(voltageSelect),
        .deviceActive(deviceActive), .cfgOut(cfgOut)
    );

    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic chkBit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : chkBit

    task automatic chkByte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chkByte

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : settle

    task automatic t_reset;
        logic [7:0] v;
        logic       a;
        host_u.rdReg(DEV_ADDR, v, a);
        chkBit("rdAck", 1'b1, a);
        chkByte("cfgReset", 8'h00, v);
        chkBit("regOn", 1'b1, regulatorEnable);
        chkBit("volt18", 1'b0, voltageSelect);
        chkBit("idle", 1'b0, deviceActive);
        $display("test reset done");
    endtask : t_reset

    task automatic t_wr_rd;
        logic [7:0] v;
        logic       a;
        host_u.wrReg(DEV_ADDR, 8'h87, a);
        chkBit("wrAck", 1'b1, a);
        settle(8);
        host_u.rdReg(DEV_ADDR, v, a);
        chkByte("cfgRead", 8'h83, v);
        chkBit("regOff", 1'b0, regulatorEnable);
        chkBit("volt3", 1'b1, voltageSelect);
        chkBit("active", 1'b1, deviceActive);
        hostClkIn = 1'b1;
        settle(4);
        chkBit("clkPath", 1'b1, cardClockOut);
        $display("test wr_rd done");
    endtask : t_wr_rd

    task automatic t_pin_mode;
        logic [7:0] v;
        logic       a;
        hostRstEnIn = 1'b0;
        host_u.wrReg(DEV_ADDR, 8'h69, a);
        settle(8);
        chkBit("enLow", 1'b1, deviceActive);
        chkBit("rstHigh", 1'b1, cardResetOut);
        host_u.rdReg(DEV_ADDR, v, a);
        chkByte("pinStat0", 8'h68, v);
        hostRstEnIn = 1'b1;
        settle(4);
        chkBit("disLow", 1'b0, deviceActive);
        host_u.rdReg(DEV_ADDR, v, a);
        chkByte("pinStat1", 8'h69, v);
        host_u.wrReg(DEV_ADDR, 8'h40, a);
        settle(8);
        chkBit("enHigh", 1'b1, deviceActive);
        chkBit("rstLow", 1'b0, cardResetOut);
        $display("test pin_mode done");
    endtask : t_pin_mode

    task automatic t_latch;
        logic a;
        hostClkIn = 1'b1;
        hostDrv = 1'b0;
        host_u.wrReg(DEV_ADDR, 8'h01, a);
        settle(8);
        chkBit("rstPass1", 1'b1, cardResetOut);
        chkBit("dataPass", 1'b0, cardDataIn);
        hostRstEnIn = 1'b0;
        settle(4);
        chkBit("rstPass0", 1'b0, cardResetOut);
        hostRstEnIn = 1'b1;
        host_u.wrReg(DEV_ADDR, 8'h11, a);
        settle(8);
        hostClkIn = 1'b0;
        hostRstEnIn = 1'b0;
        hostDrv = 1'b1;
        settle(6);
        chkBit("clkHeld", 1'b1, cardClockOut);
        chkBit("rstHeld", 1'b1, cardResetOut);
        chkBit("dataHeld", 1'b0, cardDataIn);
        host_u.wrReg(DEV_ADDR, 8'h01, a);
        settle(8);
        chkBit("clkFree", 1'b0, cardClockOut);
        chkBit("dataFree", 1'b1, cardDataIn);
        cardDrv = 1'b0;
        settle(4);
        chkBit("cardToHost", 1'b0, hostDataIn);
        cardDrv = 1'b1;
        settle(4);
        chkBit("hostFree", 1'b1, hostDataIn);
        $display("test latch done");
    endtask : t_latch

    task automatic t_refuse;
        logic [7:0] v;
        logic       a;
        host_u.rdReg(DEV_ADDR ^ 7'h01, v, a);
        chkBit("wrongAddr", 1'b0, a);
        host_u.busyProbe(DEV_ADDR, 8'h02, a);
        chkBit("busyAck", 1'b0, a);
        settle(4);
        host_u.rdReg(DEV_ADDR, v, a);
        chkBit("rdAck", 1'b1, a);
        chkByte("applied", 8'h02, v);
        chkBit("disabled", 1'b0, deviceActive);
        $display("test refuse done");
    endtask : t_refuse

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_wr_rd();
        t_pin_mode();
        t_latch();
        t_refuse();
        print_verdict();
    end
endmodule : tb
